//--- logic/pipe_cfg.svh
// Constants for the instruction pipeline control block.
`ifndef PIPE_CFG_SVH
`define PIPE_CFG_SVH
`define PIPE_PC_W 20
`define PIPE_WORD_W 16
`define PIPE_PC_STEP 20'h00002
`define PIPE_PC_LEAD 20'h00006
`define PIPE_PC_RESET 20'h00000
`define PIPE_PRE_PG1 8'h17
`define PIPE_PRE_PG2 8'h27
`define PIPE_PRE_PG3 8'h37
`define PIPE_EXEC_MIN 4'h1
`endif

//--- logic/pipe_pkg.sv
// Types shared by the instruction pipeline control block.
package pipe_pkg;
    typedef enum logic [1:0]
    {
        EX_IDLE = 2'b00,
        EX_RUN = 2'b01,
        EX_FLUSH = 2'b10
    } exec_state_t;
    typedef logic [15:0] word_t;
endpackage : pipe_pkg

//--- logic/pipe_stage.sv
// One pipeline stage register holding a word and a valid flag.
module pipe_stage #(
    parameter int W = 16
) (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic flush_i,
    input wire logic load_i,
    input wire logic [W-1:0] data_i,
    input wire logic valid_i,
    output logic [W-1:0] data_o,
    output logic valid_o
);
    // Flush has priority so that old-stream words never survive a flow change.
    always_ff @(posedge mclk_i)
    begin
        if (reset_i || flush_i)
        begin
            data_o <= '0;
            valid_o <= 1'b0;
        end
        else if (load_i)
        begin
            data_o <= data_i;
            valid_o <= valid_i;
        end
    end
endmodule : pipe_stage

//--- logic/instruction_pipeline_control.sv
// Fetch sequencing, three-stage instruction pipeline and execution control.
//
// Function
// - Three-stage FIFO holds instructions: A, B, C.
// - Up to three single-word instructions held.
// - Fetched words enter A, evaluated in B.
// - Operands from A or B; B only 8-bit.
// - Completed opcode moves B to C, stays.
// - Prefetch reads ahead, increments program counter.
// - PC equals instruction address plus six.
// - Sequencer drives two tracking outputs.
// - Sequencer, pipeline, execution run concurrently.
// - Execution evaluates opcodes, advances pipeline.
// - Execution length varies with instruction.
// - Fetch words from even addresses only.
// - Prebytes 17, 27, 37 select pages 1-3.
// - Flow change flushes stages A and B.
`include "pipe_cfg.svh"
module instruction_pipeline_control #(
    parameter int PC_W = `PIPE_PC_W
) (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic fetch_ack_i,
    input wire pipe_pkg::word_t fetch_data_i,
    input wire logic exec_done_i,
    input wire logic flow_change_i,
    input wire logic [PC_W-1:0] flow_target_i,
    input wire logic operand_sel_b_i,
    output logic fetch_req_o,
    output logic [PC_W-1:0] fetch_addr_o,
    output logic [PC_W-1:0] pc_o,
    output logic [PC_W-1:0] inst_addr_o,
    output logic exec_start_o,
    output logic exec_busy_o,
    output logic [7:0] opcode_o,
    output logic [1:0] opcode_page_o,
    output pipe_pkg::word_t operand_o,
    output pipe_pkg::word_t stage_c_o,
    output logic pipe_track_out_0,
    output logic pipe_track_out_1
);
    import pipe_pkg::*;

    exec_state_t state_r;
    exec_state_t state_nxt;
    logic [PC_W-1:0] pc_r;
    logic [PC_W-1:0] a_addr;
    logic [PC_W-1:0] b_addr;
    logic [1:0] page_nxt;
    word_t a_data;
    word_t b_data;
    word_t c_data;
    logic a_valid;
    logic b_valid;
    logic c_valid;

    // Stage control: B loads from A when B is free or its instruction retires.
    // A redirect wins over everything in its cycle except the retire into C: no advance, no start, no fetch,
    // because any word moved then would belong to the stream being thrown away.
    wire logic b_free = !b_valid || (state_r == EX_RUN && exec_done_i);
    wire logic adv_ab = a_valid && b_free && !flow_change_i;
    wire logic a_load = fetch_ack_i && (!a_valid || adv_ab);
    wire logic retire = state_r == EX_RUN && exec_done_i;
    wire logic flush_ab = flow_change_i;
    wire logic b_leaves = retire && !adv_ab;
    wire logic [7:0] b_hi = b_data[15:8];
    wire logic is_pre1 = b_hi == `PIPE_PRE_PG1;
    wire logic is_pre2 = b_hi == `PIPE_PRE_PG2;
    wire logic is_pre3 = b_hi == `PIPE_PRE_PG3;
    wire logic is_pre = is_pre1 || is_pre2 || is_pre3;
    wire logic start = b_valid && state_r == EX_IDLE && !flow_change_i;
    wire logic [PC_W-1:0] pc_inc = PC_W'(pc_r + `PIPE_PC_STEP);
    wire logic [PC_W-1:0] pc_lead = PC_W'(b_addr + `PIPE_PC_LEAD);
    wire logic [PC_W-1:0] target_even = {flow_target_i[PC_W-1:1], 1'b0};

    // Page select: a prebyte in the high byte sets the page for the low byte.
    assign page_nxt = is_pre1 ? 2'd1 : is_pre2 ? 2'd2 : is_pre3 ? 2'd3 : 2'd0;

    // Three stages of the FIFO, all running alongside fetch and execution.
    pipe_stage #(.W(16)) u_stage_a (
        .mclk_i(mclk_i), .reset_i(reset_i), .flush_i(flush_ab), .load_i(a_load || adv_ab),
        .data_i(fetch_data_i), .valid_i(a_load), .data_o(a_data), .valid_o(a_valid));
    pipe_stage #(.W(16)) u_stage_b (
        .mclk_i(mclk_i), .reset_i(reset_i), .flush_i(flush_ab), .load_i(adv_ab || b_leaves),
        .data_i(a_data), .valid_i(adv_ab), .data_o(b_data), .valid_o(b_valid));
    pipe_stage #(.W(16)) u_stage_c (
        .mclk_i(mclk_i), .reset_i(reset_i), .flush_i(1'b0), .load_i(retire),
        .data_i(b_data), .valid_i(1'b1), .data_o(c_data), .valid_o(c_valid));

    // The fetch address of each word travels beside it through A and B.
    // This costs two address registers but lets a start know its own address exactly,
    // however slow the memory was while the word was on its way.
    pipe_stage #(.W(PC_W)) u_addr_a (
        .mclk_i(mclk_i), .reset_i(reset_i), .flush_i(flush_ab), .load_i(a_load || adv_ab),
        .data_i(pc_r), .valid_i(a_load), .data_o(a_addr), .valid_o());
    pipe_stage #(.W(PC_W)) u_addr_b (
        .mclk_i(mclk_i), .reset_i(reset_i), .flush_i(flush_ab), .load_i(adv_ab || b_leaves),
        .data_i(a_addr), .valid_i(adv_ab), .data_o(b_addr), .valid_o());

    // Execution sequencing; length is set by exec_done_i, not a fixed count.
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            EX_IDLE: if (start) state_nxt = EX_RUN;
            EX_RUN: if (flow_change_i) state_nxt = EX_FLUSH;
                    else if (exec_done_i) state_nxt = EX_IDLE;
            EX_FLUSH: state_nxt = EX_IDLE;
            default: state_nxt = EX_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            state_r <= EX_IDLE;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // Program counter steps one word per accepted fetch, even addresses only.
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
            pc_r <= `PIPE_PC_RESET;
        else if (flow_change_i)
            pc_r <= target_even;
        else if (a_load)
            pc_r <= pc_inc;
    end

    // At start the visible program counter is the instruction's address plus six bytes.
    // The fetch pointer may lag that point while memory is slow, so the visible value is
    // built from the address carried with the word, not from the fetch pointer.
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            pc_o <= '0;
            inst_addr_o <= '0;
        end
        else if (start)
        begin
            pc_o <= pc_lead;
            inst_addr_o <= b_addr;
        end
    end

    // Registered outputs, including the two tracking signals.
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            fetch_req_o <= 1'b0;
            fetch_addr_o <= '0;
            exec_start_o <= 1'b0;
            exec_busy_o <= 1'b0;
            opcode_o <= 8'h00;
            opcode_page_o <= 2'd0;
            operand_o <= 16'h0000;
            stage_c_o <= 16'h0000;
            pipe_track_out_0 <= 1'b0;
            pipe_track_out_1 <= 1'b0;
        end
        else
        begin
            fetch_req_o <= !flow_change_i;
            fetch_addr_o <= flow_change_i ? target_even : (a_load ? pc_inc : pc_r);
            exec_start_o <= start;
            exec_busy_o <= state_r == EX_RUN;
            opcode_o <= is_pre ? b_data[7:0] : b_hi;
            opcode_page_o <= is_pre ? page_nxt : 2'd0;
            operand_o <= operand_sel_b_i ? {8'h00, b_data[7:0]} : a_data;
            stage_c_o <= c_valid ? c_data : 16'h0000;
            pipe_track_out_0 <= adv_ab;
            pipe_track_out_1 <= start || retire;
        end
    end

    // Checks on sequencing, stall and flush behaviour. The stall and flush checks watch the stage flags rather
    // than the decode wires, so a broken stage load is caught and not only a bad equation.
    chk_stall_empty_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        !a_valid && !b_valid |=> !b_valid) else $error("B filled from empty stage A");
    chk_resume_a_b: assert property (@(posedge mclk_i) disable iff (reset_i)
        a_valid && !b_valid && !flow_change_i |=> b_valid) else $error("stall not released");
    chk_flush_ab: assert property (@(posedge mclk_i) disable iff (reset_i)
        flow_change_i |=> !a_valid && !b_valid) else $error("flush left words");
    chk_req_after_flow: assert property (@(posedge mclk_i) disable iff (reset_i)
        flow_change_i |=> !fetch_req_o && fetch_addr_o == $past(target_even))
        else $error("redirect fetch wrong");
    chk_pc_even: assert property (@(posedge mclk_i) disable iff (reset_i)
        pc_r[0] == 1'b0) else $error("odd fetch address");
    chk_pc_step: assert property (@(posedge mclk_i) disable iff (reset_i)
        a_load && !flow_change_i |=> pc_r == $past(pc_r) + `PIPE_PC_STEP)
        else $error("pc step wrong");
    chk_pc_lead: assert property (@(posedge mclk_i) disable iff (reset_i)
        start |=> pc_o == inst_addr_o + `PIPE_PC_LEAD) else $error("pc lead wrong");
    chk_addr_follow: assert property (@(posedge mclk_i) disable iff (reset_i)
        adv_ab |=> b_addr == $past(a_addr)) else $error("B address lost");
    chk_start_run: assert property (@(posedge mclk_i) disable iff (reset_i)
        start |=> state_r == EX_RUN && exec_start_o) else $error("start not taken");
    chk_retire_c: assert property (@(posedge mclk_i) disable iff (reset_i)
        retire |=> c_data == $past(b_data) && c_valid) else $error("C not loaded");
    chk_c_hold: assert property (@(posedge mclk_i) disable iff (reset_i)
        !retire |=> c_data == $past(c_data)) else $error("C changed");
    chk_track_adv: assert property (@(posedge mclk_i) disable iff (reset_i)
        adv_ab |=> pipe_track_out_0) else $error("track 0 missed");
    chk_track_start: assert property (@(posedge mclk_i) disable iff (reset_i)
        start || retire |=> pipe_track_out_1) else $error("track 1 missed");
    chk_operand_b: assert property (@(posedge mclk_i) disable iff (reset_i)
        operand_sel_b_i |=> operand_o[15:8] == 8'h00) else $error("B operand wide");
    chk_page_sel: assert property (@(posedge mclk_i) disable iff (reset_i)
        b_valid && b_hi == `PIPE_PRE_PG2 |=> opcode_page_o == 2'd2) else $error("page wrong");
    cov_three_full: cover property (@(posedge mclk_i) a_valid && b_valid && c_valid);
    cov_flush: cover property (@(posedge mclk_i) state_r == EX_RUN && flow_change_i);
    cov_prebyte: cover property (@(posedge mclk_i) start && is_pre);
    cov_starved: cover property (@(posedge mclk_i) state_r == EX_IDLE && !a_valid && !b_valid);
endmodule : instruction_pipeline_control

//--- dv/fetch_mem_model.sv
// Behavioural instruction memory that answers the block's prefetch requests.
module fetch_mem_model (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic req_i,
    input wire logic [19:0] addr_i,
    output logic ack_o,
    output pipe_pkg::word_t data_o
);
    import pipe_pkg::*;

    // Word at an address; the low address bits pick a prebyte so every page is exercised.
    function automatic word_t mem_word(input logic [19:0] a);
        return {(a[2:1] == 2'b00) ? {4'h8, a[6:3]} : {2'b00, a[2:1], 4'h7}, a[8:1]};
    endfunction : mem_word

    logic go_r = 1'b0;

    // A random ready decision per cycle makes the memory slow at times, starving stage A.
    always @(posedge mclk_i)
    begin
        go_r <= ($urandom % 3 != 0);
    end

    // The answer always belongs to the address shown now, so a redirect never picks up an
    // old-stream word; a released bus shows the inverse word, not the last one.
    assign ack_o = req_i && go_r && !reset_i;
    assign data_o = ack_o ? mem_word(addr_i) : ~mem_word(addr_i);
endmodule : fetch_mem_model

//--- dv/test_instruction_pipeline_control.sv
// Self-checking testbench for the instruction pipeline control block.
module test_instruction_pipeline_control;
    timeunit 1ns;
    timeprecision 1ps;
    import pipe_pkg::*;
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic fetch_ack_i;
    word_t fetch_data_i;
    logic exec_done_i = 1'b0;
    logic flow_change_i = 1'b0;
    logic [19:0] flow_target_i = 20'h00000;
    logic operand_sel_b_i = 1'b0;
    logic fetch_req_o;
    logic [19:0] fetch_addr_o;
    logic exec_start_o;
    logic exec_busy_o;
    logic [7:0] opcode_o;
    logic [1:0] opcode_page_o;
    word_t stage_c_o;
    logic [19:0] pc_o;
    logic [19:0] inst_addr_o;
    word_t operand_o;
    logic pipe_track_out_1;
    int failures = 0;
    int checks = 0;
    logic [35:0] exp_q[$];
    logic [35:0] e;
    logic [19:0] exp_addr = 20'h00000;
    word_t prev_word;
    word_t w;

    instruction_pipeline_control i_dut (.mclk_i, .reset_i, .fetch_ack_i, .fetch_data_i,
        .exec_done_i, .flow_change_i, .flow_target_i, .operand_sel_b_i, .fetch_req_o,
        .fetch_addr_o, .pc_o, .inst_addr_o, .exec_start_o, .exec_busy_o, .opcode_o,
        .opcode_page_o, .operand_o, .stage_c_o, .pipe_track_out_0(), .pipe_track_out_1);

    fetch_mem_model i_mem (.mclk_i, .reset_i, .req_i(fetch_req_o), .addr_i(fetch_addr_o),
        .ack_o(fetch_ack_i), .data_o(fetch_data_i));

    always #5 mclk_i = ~mclk_i;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_addr(input logic [19:0] got, input logic [19:0] exp);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t: address got %h expected %h", $time, got, exp);
        end
    endtask : chk_addr

    // Same memory image as the partner model: low address bits pick the prebyte.
    function automatic word_t mem_word(input logic [19:0] a);
        return {(a[2:1] == 2'b00) ? {4'h8, a[6:3]} : {2'b00, a[2:1], 4'h7}, a[8:1]};
    endfunction : mem_word

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : final_report

    // Retires n instructions with random lengths; the last may also redirect the stream.
    task automatic run(input int n, input logic jump, input logic [19:0] tgt);
        int k;
        for (int i = 0; i < n; i++)
        begin
            k = 0;
            do
            begin
                @(posedge mclk_i);
                k++;
            end
            while (exec_start_o !== 1'b1 && k < 60);
            if (exec_start_o !== 1'b1)
            begin
                failures++;
                $display("Error at %0t: execution never started", $time);
                final_report();
            end
            repeat ($urandom % 4) @(posedge mclk_i);
            exec_done_i <= 1'b1;
            operand_sel_b_i <= 1'($urandom);
            prev_word = mem_word(exp_addr);
            if (jump && i == n - 1)
            begin
                flow_change_i <= 1'b1;
                flow_target_i <= tgt;
                exp_addr = tgt & 20'hffffe;
            end
            else
                exp_addr = exp_addr + 20'h00002;
            exp_q.push_back({exp_addr, prev_word});
            @(posedge mclk_i);
            exec_done_i <= 1'b0;
            flow_change_i <= 1'b0;
        end
    endtask : run

    // Each execution start is checked against the oldest expectation.
    always @(posedge mclk_i)
    begin
        if (exec_start_o === 1'b1)
        begin
            if (exp_q.size() == 0)
            begin
                failures++;
                $display("Error at %0t: unexpected execution start", $time);
            end
            else
            begin
                e = exp_q.pop_front();
                w = mem_word(e[35:16]);
                chk({8'h00, opcode_o}, {8'h00, (e[18:17] != 2'b00) ? w[7:0] : w[15:8]});
                chk({14'h0000, opcode_page_o}, {14'h0000, e[18:17]});
                chk(stage_c_o, e[15:0]);
                chk_addr(inst_addr_o, e[35:16]);
                chk_addr(pc_o, e[35:16] + 20'h00006);
                chk({15'h0000, pipe_track_out_1}, 16'h0001);
                if (operand_sel_b_i === 1'b1)
                    chk(operand_o, {8'h00, w[7:0]});
            end
        end
        // Completion is only offered while the block reports that it is executing.
        if (exec_done_i === 1'b1)
            chk({15'h0000, exec_busy_o}, 16'h0001);
    end

    initial
    begin
        void'($urandom(21152));
        exp_q.push_back(36'h000000000);
        repeat (6) @(posedge mclk_i);
        reset_i <= 1'b0;
        run(8, 1'b1, 20'h00101);
        $display("Test sequential stream and odd jump done");
        run(5, 1'b1, 20'h00040);
        $display("Test second jump done");
        run(6, 1'b0, 20'h00000);
        $display("Test plain stream done");
        final_report();
    end
endmodule : test_instruction_pipeline_control
